// ### hdl/ltl_cmp.sv
/*
  Limit comparator: scales result and both limits to lux, counts
  consecutive out-of-limit conversions and raises the flags.
  Assumes result words arrive with a one-cycle valid on clk_sys_i.
*/
`timescale 1ns/1ns
`include "ltl_defs.svh"

module ltl_cmp
  import ltl_pkg::*;
#(
  parameter int MANT_W = 12,
  parameter int EXP_W = 4
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  ltl_cmp_if.cmp cif
);

  if (MANT_W + EXP_W != 16 || EXP_W != 4)
  begin : g_bad_width
    $error("ltl_cmp serves only a 4-bit exponent and 12-bit mantissa");
  end

  ltl_cmp_state_t s_reg;
  ltl_cmp_state_t s_next;
  logic below;
  logic above;
  logic [3:0] need;

  always_comb
  begin
    s_next = s_reg;
    // result exponent is used unmasked here, masking is a read-back matter
    below = ltl_lux_f(cif.result) < ltl_lux_f(cif.lower);
    above = ltl_lux_f(cif.result) > ltl_lux_f(cif.upper);
    need = ltl_need_f(cif.fault_count);
    if (cif.result_valid)
    begin
      if (below)
      begin
        if (s_reg.cnt_lo < need)
          s_next.cnt_lo = 4'(s_reg.cnt_lo + 4'h1);
        if (4'(s_reg.cnt_lo + 4'h1) >= need)
          s_next.flag_lo = 1'b1;
      end
      else
      begin
        s_next.cnt_lo = 4'h0;
        s_next.flag_lo = 1'b0;
      end
      if (above)
      begin
        if (s_reg.cnt_hi < need)
          s_next.cnt_hi = 4'(s_reg.cnt_hi + 4'h1);
        if (4'(s_reg.cnt_hi + 4'h1) >= need)
          s_next.flag_hi = 1'b1;
      end
      else
      begin
        s_next.cnt_hi = 4'h0;
        s_next.flag_hi = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign cif.below_flag = s_reg.flag_lo;
  assign cif.above_flag = s_reg.flag_hi;

  chk_low_flag_set: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cif.result_valid && below && (4'(s_reg.cnt_lo + 4'h1) >= need)
    |=> cif.below_flag)
    else $error("below flag not set after enough low conversions");

  chk_one_fault_code: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cif.result_valid && above && cif.fault_count == 2'b00
    |=> cif.above_flag)
    else $error("code 00 did not flag on the first high conversion");

  chk_two_fault_wait: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cif.result_valid && below && cif.fault_count == 2'b01 &&
    s_reg.cnt_lo == 4'h0 && !cif.below_flag
    |=> !cif.below_flag)
    else $error("code 01 flagged after a single low conversion");

  chk_inside_clears: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cif.result_valid && !below && !above
    |=> !cif.below_flag && !cif.above_flag)
    else $error("flag stayed up after an in-limit conversion");

  chk_full_scale: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cif.upper == 16'hbfff |-> ltl_lux_f(cif.upper) == `LTL_FULL_SCALE_TOP)
    else $error("top exponent does not reach full scale");

  cov_low_flag: cover property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) $rose(cif.below_flag));

  cov_high_flag: cover property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) $rose(cif.above_flag));

endmodule : ltl_cmp

// ### hdl/ltl_cmp_if.sv
/*
  Carrier between the register bank and its limit comparator.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns

interface ltl_cmp_if;
  logic [15:0] lower;
  logic [15:0] upper;
  logic [15:0] result;
  logic result_valid;
  logic [1:0] fault_count;
  logic below_flag;
  logic above_flag;

  modport regs (
    output lower,
    output upper,
    output result,
    output result_valid,
    output fault_count,
    input below_flag,
    input above_flag
  );

  modport cmp (
    input lower,
    input upper,
    input result,
    input result_valid,
    input fault_count,
    output below_flag,
    output above_flag
  );
endinterface : ltl_cmp_if

// ### hdl/ltl_defs.svh
/*
  Constants of the light threshold register bank: register offsets,
  field positions, reset values and lux scaling figures.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef LTL_DEFS_SVH
`define LTL_DEFS_SVH

`define LTL_LOWER_OFS 8'h02
`define LTL_UPPER_OFS 8'h03
`define LTL_MAKER_OFS 8'h7e
`define LTL_PART_OFS 8'h7f

`define LTL_LOWER_RST 16'h0000
`define LTL_UPPER_RST 16'hbfff

`define LTL_EXP_MSB 15
`define LTL_EXP_LSB 12
`define LTL_MANT_MSB 11
`define LTL_MANT_LSB 0

// internal lux unit is 0.01 lux, so one mantissa step at exponent 0
`define LTL_LUX_W 27
`define LTL_FULL_SCALE_TOP 27'h7ff800

`define LTL_UNMAPPED_READ 16'h0000

`endif

// ### hdl/ltl_pkg.sv
/*
  Types and shared functions of the light threshold register bank.
  Assumes ltl_defs.svh is reachable on the include path.
*/
`include "ltl_defs.svh"

package ltl_pkg;

  typedef enum logic [2:0] {
    LTL_ST_IDLE = 3'b000,
    LTL_ST_ADDR = 3'b001,
    LTL_ST_RX = 3'b010,
    LTL_ST_ACK = 3'b011,
    LTL_ST_RD = 3'b100,
    LTL_ST_MACK = 3'b101
  } ltl_state_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    ltl_state_t st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic got_ptr;
    logic hi;
    logic rd_lo;
    logic ackd;
    logic oe;
    logic [7:0] ptr;
    logic [7:0] hold;
    logic [15:0] rdata;
    logic [15:0] lower;
    logic [15:0] upper;
  } ltl_bus_state_t;

  typedef struct packed {
    logic [3:0] cnt_lo;
    logic [3:0] cnt_hi;
    logic flag_lo;
    logic flag_hi;
  } ltl_cmp_state_t;

  // threshold or result word to a common scale in 0.01 lux steps
  function automatic logic [`LTL_LUX_W-1:0] ltl_lux_f(input logic [15:0] v);
    logic [`LTL_LUX_W-1:0] m;
    m = `LTL_LUX_W'(v[`LTL_MANT_MSB:`LTL_MANT_LSB]);
    return m << v[`LTL_EXP_MSB:`LTL_EXP_LSB];
  endfunction : ltl_lux_f

  // fault count code to consecutive conversions needed: 1, 2, 4, 8
  function automatic logic [3:0] ltl_need_f(input logic [1:0] fc);
    return 4'h1 << fc;
  endfunction : ltl_need_f

endpackage : ltl_pkg

// ### hdl/ltl_regs.sv
/*
  Light threshold register bank behind a two-wire serial slave:
  lower and upper lux limits, maker and part identity words, and the
  limit comparator that drives the below and above flags.
  Assumes scl_i and sda_i come from pins outside clk_sys_i's domain,
  a bus clock well below a quarter of clk_sys_i, and an external
  open-drain pad that pulls sda low while sda_oe_o is high.
*/
`timescale 1ns/1ns
`include "ltl_defs.svh"

//Operation
// - lower limit is 16-bit read/write: exponent 15:12, mantissa 11:0
// - limit value in lux is 0.01 times two to exponent times mantissa
// - exponents 0 to 11 double the full scale, 40.95 up to 83865.60 lux
// - result and limits are compared on a common lux scale
// - comparison uses the true result exponent, never the masked one
// - lower limit lives at offset 02h and resets to zero
// - upper limit lives at offset 03h and resets to bfffh
// - lower limit is the threshold behind the below flag, upper limit behind the above flag
// - read-only maker identity word at offset 7eh
// - read-only part identity word at offset 7fh
// - below flag sets after enough consecutive conversions under limit
// - 2-bit fault count picks 1, 2, 4 or 8 conversions
module ltl_regs
  import ltl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  // identity values are arbitrary
  parameter logic [15:0] MAKER_CODE = 16'h1a2b,
  parameter logic [15:0] PART_CODE = 16'h0c0d
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [15:0] result_i,
  input wire logic result_valid_i,
  input wire logic [1:0] consecutive_fault_count_i,
  output logic below_limit_flag_o,
  output logic above_limit_flag_o
);

  if (DEV_ADDR == 7'h00 || DEV_ADDR[6:3] == 4'hf)
  begin : g_bad_addr
    $error("ltl_regs bus address falls in a reserved block");
  end

  localparam ltl_bus_state_t RESET_STATE = '{
    st: LTL_ST_IDLE,
    scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
    lower: `LTL_LOWER_RST,
    upper: `LTL_UPPER_RST,
    default: '0
  };

  ltl_bus_state_t s_reg;
  ltl_bus_state_t s_next;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [7:0] rx_byte;
  logic [15:0] rd_word;
  logic wr_commit;
  logic [15:0] wr_word;

  ltl_cmp_if cif ();

  always_comb
  begin
    s_next = s_reg;
    wr_commit = 1'b0;
    wr_word = {s_reg.hold, s_reg.sh[6:0], s_reg.sda_s};
    rx_byte = {s_reg.sh[6:0], s_reg.sda_s};
    // the first stages only feed the second stages
    s_next.scl_m = scl_i;
    s_next.scl_s = s_reg.scl_m;
    s_next.scl_d = s_reg.scl_s;
    s_next.sda_m = sda_i;
    s_next.sda_s = s_reg.sda_m;
    s_next.sda_d = s_reg.sda_s;
    rise = !s_reg.scl_d && s_reg.scl_s;
    fall = s_reg.scl_d && !s_reg.scl_s;
    start = s_reg.scl_s && s_reg.sda_d && !s_reg.sda_s;
    stop = s_reg.scl_s && !s_reg.sda_d && s_reg.sda_s;
    case (s_reg.ptr)
      `LTL_LOWER_OFS: rd_word = s_reg.lower;
      `LTL_UPPER_OFS: rd_word = s_reg.upper;
      `LTL_MAKER_OFS: rd_word = MAKER_CODE;
      `LTL_PART_OFS: rd_word = PART_CODE;
      default: rd_word = `LTL_UNMAPPED_READ;
    endcase
    if (start)
    begin
      s_next.st = LTL_ST_ADDR;
      s_next.cnt = 3'h0;
      s_next.oe = 1'b0;
      s_next.got_ptr = 1'b0;
      s_next.hi = 1'b0;
    end
    else if (stop)
    begin
      s_next.st = LTL_ST_IDLE;
      s_next.oe = 1'b0;
    end
    else
    begin
      case (s_reg.st)
        LTL_ST_IDLE: ;
        LTL_ST_ADDR:
          if (rise)
          begin
            s_next.sh = rx_byte;
            s_next.cnt = 3'(s_reg.cnt + 3'h1);
            if (s_reg.cnt == 3'h7)
            begin
              s_next.rw = s_reg.sda_s;
              s_next.ackd = 1'b0;
              s_next.st = (s_reg.sh[6:0] == DEV_ADDR) ? LTL_ST_ACK
                                                       : LTL_ST_IDLE;
            end
          end
        LTL_ST_ACK:
          if (fall)
          begin
            if (!s_reg.ackd)
            begin
              s_next.oe = 1'b1;
              s_next.ackd = 1'b1;
            end
            else
            begin
              s_next.ackd = 1'b0;
              s_next.cnt = 3'h0;
              if (s_reg.rw)
              begin
                s_next.rdata = rd_word;
                s_next.oe = ~rd_word[15];
                s_next.rd_lo = 1'b0;
                s_next.st = LTL_ST_RD;
              end
              else
              begin
                s_next.oe = 1'b0;
                s_next.st = LTL_ST_RX;
              end
            end
          end
        LTL_ST_RX:
          if (rise)
          begin
            s_next.sh = rx_byte;
            s_next.cnt = 3'(s_reg.cnt + 3'h1);
            if (s_reg.cnt == 3'h7)
            begin
              s_next.st = LTL_ST_ACK;
              s_next.ackd = 1'b0;
              if (!s_reg.got_ptr)
              begin
                s_next.ptr = rx_byte;
                s_next.got_ptr = 1'b1;
                s_next.hi = 1'b0;
              end
              else if (!s_reg.hi)
              begin
                s_next.hold = rx_byte;
                s_next.hi = 1'b1;
              end
              else
              begin
                s_next.hi = 1'b0;
                wr_commit = 1'b1;
              end
            end
          end
        LTL_ST_RD:
          if (fall)
          begin
            s_next.cnt = 3'(s_reg.cnt + 3'h1);
            s_next.rdata = {s_reg.rdata[14:0], 1'b0};
            if (s_reg.cnt == 3'h7)
            begin
              s_next.oe = 1'b0;
              s_next.ackd = 1'b0;
              s_next.st = LTL_ST_MACK;
            end
            else
              s_next.oe = ~s_reg.rdata[14];
          end
        LTL_ST_MACK:
          if (rise)
          begin
            if (s_reg.sda_s)
              s_next.st = LTL_ST_IDLE;
            else
              s_next.ackd = 1'b1;
          end
          else if (fall && s_reg.ackd)
          begin
            s_next.cnt = 3'h0;
            s_next.st = LTL_ST_RD;
            s_next.rd_lo = ~s_reg.rd_lo;
            // after the low byte the same word is sent again
            if (s_reg.rd_lo)
            begin
              s_next.rdata = rd_word;
              s_next.oe = ~rd_word[15];
            end
            else
              s_next.oe = ~s_reg.rdata[15];
          end
        default: s_next.st = LTL_ST_IDLE;
      endcase
    end
    // identity and unmapped words have no storage, so writes vanish
    if (wr_commit)
    begin
      case (s_reg.ptr)
        `LTL_LOWER_OFS: s_next.lower = wr_word;
        `LTL_UPPER_OFS: s_next.upper = wr_word;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      s_reg <= RESET_STATE;
    else
      s_reg <= s_next;
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = s_reg.oe;
  assign cif.lower = s_reg.lower;
  assign cif.upper = s_reg.upper;
  assign cif.result = result_i;
  assign cif.result_valid = result_valid_i;
  assign cif.fault_count = consecutive_fault_count_i;
  assign below_limit_flag_o = cif.below_flag;
  assign above_limit_flag_o = cif.above_flag;

  ltl_cmp #(
    .MANT_W(12),
    .EXP_W(4)
  ) u_cmp (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .cif(cif.cmp)
  );

  chk_limit_reset: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> s_reg.lower == 16'h0000 && s_reg.upper == 16'hbfff)
    else $error("limits not at reset values after reset");

  chk_lower_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_commit && s_reg.ptr == 8'h02 |=> s_reg.lower == $past(wr_word))
    else $error("lower limit did not take the written word");

  chk_upper_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_commit && s_reg.ptr == 8'h03 |=> s_reg.upper == $past(wr_word))
    else $error("upper limit did not take the written word");

  chk_id_write_void: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_commit && s_reg.ptr[7:1] == 7'h3f
    |=> $stable(s_reg.lower) && $stable(s_reg.upper))
    else $error("identity write disturbed a limit");

  chk_maker_read: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_reg.st == LTL_ST_RD && $past(s_reg.st) == LTL_ST_ACK &&
    s_reg.ptr == 8'h7e |-> s_reg.rdata == MAKER_CODE)
    else $error("maker identity read back wrong");

  chk_part_read: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_reg.st == LTL_ST_RD && $past(s_reg.st) == LTL_ST_ACK &&
    s_reg.ptr == 8'h7f |-> s_reg.rdata == PART_CODE)
    else $error("part identity read back wrong");

  chk_stop_release: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    stop && !start |=> !sda_oe_o ##1 !sda_oe_o)
    else $error("data line still held after a stop");

  cov_lower_write: cover property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_commit && s_reg.ptr == 8'h02);

  cov_maker_read: cover property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_reg.st == LTL_ST_MACK && s_reg.ptr == 8'h7e && s_reg.rd_lo);

endmodule : ltl_regs

// ### verif/ltl_host_model.sv
/*
  Host model on the two-wire bus: start, stop, byte transfers and
  register write and read sequences, one bit every 8 system clocks.
  Assumes the bench forms the wire level from sda_o and the device.
*/
`timescale 1ns/1ns

module ltl_host_model
(
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // lines released at rest; scl stands high between frames
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wait_clk

  // sda moves one clock after scl fell, never beside an scl edge
  task automatic bit_x(input logic b, output logic r);
    wait_clk(1);
    sda_o <= b;
    wait_clk(4);
    scl_o <= 1'b1;
    wait_clk(3);
    r = sda_i;
    scl_o <= 1'b0;
  endtask : bit_x

  // long low phase lets the device drop its acknowledge first
  task automatic start_x();
    wait_clk(1);
    sda_o <= 1'b1;
    wait_clk(6);
    scl_o <= 1'b1;
    wait_clk(4);
    sda_o <= 1'b0;
    wait_clk(4);
    scl_o <= 1'b0;
  endtask : start_x

  task automatic stop_x();
    wait_clk(1);
    sda_o <= 1'b0;
    wait_clk(6);
    scl_o <= 1'b1;
    wait_clk(4);
    sda_o <= 1'b1;
    wait_clk(8);
  endtask : stop_x

  task automatic byte_x(input logic [7:0] d, input logic ack_i,
                        output logic [7:0] q, output logic ack_o);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ack_i, ack_o);
  endtask : byte_x

  // ok is high only when every byte was acknowledged
  task automatic write_word(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [15:0] w, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start_x();
    byte_x({dev, 1'b0}, 1'b1, q, a0);
    byte_x(ptr, 1'b1, q, a1);
    byte_x(w[15:8], 1'b1, q, a2);
    byte_x(w[7:0], 1'b1, q, a3);
    stop_x();
    ok = ~(a0 | a1 | a2 | a3);
  endtask : write_word

  task automatic read_word(input logic [6:0] dev, input logic [7:0] ptr,
                           output logic [15:0] w, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start_x();
    byte_x({dev, 1'b0}, 1'b1, q, a0);
    byte_x(ptr, 1'b1, q, a1);
    start_x();
    byte_x({dev, 1'b1}, 1'b1, q, a2);
    byte_x(8'hff, 1'b0, w[15:8], a3);
    byte_x(8'hff, 1'b1, w[7:0], a3);
    stop_x();
    ok = ~(a0 | a1 | a2);
  endtask : read_word
endmodule : ltl_host_model

// ### verif/ltl_tb.sv
/*
  Self-checking bench of the light threshold register bank: register
  access over the two-wire bus and limit flags from conversion pulses.
  Assumes ltl_host_model drives the bus; sda has a pull-up.
*/
`timescale 1ns/1ns
`include "ltl_defs.svh"

`define LTL_CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("mismatch at %0t: got %0h expected %0h", \
               $time, (got), (exp)); \
    end \
  end

module testbench
  import ltl_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2a;
  // identity values are arbitrary
  localparam logic [15:0] MAKER = 16'h6d3e;
  localparam logic [15:0] PART = 16'h0b17;
  localparam int LIMIT = 20000;
  localparam logic [15:0] RES [9] = '{16'h07ff, 16'h0800, 16'h13ff,
    16'h1400, 16'h4400, 16'h4401, 16'h3200, 16'hb001, 16'hbfff};

  logic clk_sys_i, rst_n_i, scl, sda_host, sda_wire, sda_o, sda_oe_o;
  logic [15:0] result_i, low_v, up_v;
  logic result_valid_i, below, above, ok;
  logic [1:0] fc, exp_f;
  int err_total, n_tests, cycles;

  // open drain: either party pulling low wins over the pull-up
  assign sda_wire = sda_host & (~sda_oe_o | sda_o);

  ltl_regs #(.DEV_ADDR(DEV), .MAKER_CODE(MAKER), .PART_CODE(PART))
  ltl_regs_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .result_i(result_i), .result_valid_i(result_valid_i),
    .consecutive_fault_count_i(fc), .below_limit_flag_o(below),
    .above_limit_flag_o(above));

  ltl_host_model ltl_host_model_inst (.clk_sys_i(clk_sys_i),
    .sda_i(sda_wire), .scl_o(scl), .sda_o(sda_host));

  initial
    clk_sys_i = 1'b0;
  always #25 clk_sys_i = ~clk_sys_i;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_total++;
      print_verdict();
    end
  end

  function automatic logic [26:0] lux(input logic [15:0] v);
    return 27'(v[11:0]) << v[15:12];
  endfunction : lux

  task automatic wr(input logic [7:0] ptr, input logic [15:0] w);
    logic a;
    ltl_host_model_inst.write_word(DEV, ptr, w, a);
    `LTL_CHK(a, 1'b1)
  endtask : wr

  task automatic chk_rd(input logic [7:0] ptr, input logic [15:0] exp);
    logic [15:0] w;
    logic a;
    ltl_host_model_inst.read_word(DEV, ptr, w, a);
    `LTL_CHK(a, 1'b1)
    `LTL_CHK(w, exp)
  endtask : chk_rd

  // one conversion; flags are read a cycle and a half after they may move
  task automatic pulse(input logic [15:0] v);
    @(posedge clk_sys_i);
    result_i <= v;
    result_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    result_valid_i <= 1'b0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : pulse

  initial
  begin
    rst_n_i = 1'b0;
    result_i = 16'h0000;
    result_valid_i = 1'b0;
    fc = 2'b00;
    err_total = 0;
    n_tests = 0;
    cycles = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk_rd(`LTL_LOWER_OFS, 16'h0000);
    chk_rd(`LTL_UPPER_OFS, 16'hbfff);
    chk_rd(`LTL_MAKER_OFS, MAKER);
    chk_rd(`LTL_PART_OFS, PART);
    chk_rd(8'h10, 16'h0000);
    pulse(16'hbfff);
    `LTL_CHK({below, above}, 2'b00)
    pulse(16'h0000);
    `LTL_CHK({below, above}, 2'b00)
    // a foreign device address is left unanswered and changes nothing
    ltl_host_model_inst.write_word(DEV ^ 7'h01, 8'h02, 16'h1234, ok);
    `LTL_CHK(ok, 1'b0)
    wr(`LTL_MAKER_OFS, 16'hffff);
    wr(`LTL_PART_OFS, 16'h0000);
    chk_rd(`LTL_MAKER_OFS, MAKER);
    chk_rd(`LTL_PART_OFS, PART);
    chk_rd(`LTL_LOWER_OFS, 16'h0000);
    wr(`LTL_LOWER_OFS, 16'h5123);
    chk_rd(`LTL_LOWER_OFS, 16'h5123);
    wr(`LTL_UPPER_OFS, 16'ha456);
    chk_rd(`LTL_UPPER_OFS, 16'ha456);
    // a reset in mid-run must bring both limits back to their defaults
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk_rd(`LTL_LOWER_OFS, 16'h0000);
    chk_rd(`LTL_UPPER_OFS, 16'hbfff);
    // manual range 3 copied into both exponents
    low_v = 16'h3100;
    up_v = 16'h3800;
    wr(`LTL_LOWER_OFS, low_v);
    wr(`LTL_UPPER_OFS, up_v);
    foreach (RES[i])
    begin
      pulse(RES[i]);
      exp_f = {lux(RES[i]) < lux(low_v), lux(RES[i]) > lux(up_v)};
      `LTL_CHK({below, above}, exp_f)
    end
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_sys_i);
      fc <= 2'(c);
      pulse(16'h3200);
      for (int k = 1; k <= (1 << c); k++)
      begin
        pulse(16'h0001);
        `LTL_CHK(below, logic'(k == (1 << c)))
      end
    end
    print_verdict();
  end
endmodule : testbench
